// >>> design/otg_event_regs.svh
/*
 Register map, bit positions and timing constants of the OTG event-flag block.
 Assumes a 125 MHz ref_clk and a single-word register port.
*/
// Contract
// - A change of the synchronised cable identification input sets the ID change flag.
// - Each expiry of the internal 1 ms timer sets the millisecond tick flag.
// - A line state held steady for 1 ms and unlike the last reported one sets the line flag.
// - Activity on D+, D-, cable ID or bus supply that wakes a suspended block sets a flag.
// - The supply falling below the session end level sets the session valid change flag.
// - Any change of the session end comparator sets the session end change flag.
// - Any change of the supply valid comparator sets the supply valid change flag.
// - Flags are set only by hardware; writing one clears a flag and zero leaves it alone.
// - Bits 31 to 8 and bit 1 of both flag and enable registers read as zero.
// - The enable register holds one read/write enable per flag at the same bit position.
// - The block generates a 48 MHz bit-rate enable for full and low speed signalling.
// - The block runs as host, as device, or in dual-role fashion, chosen by software.
// - Handshake replies to received packets are produced by hardware alone.
// - A DMA address generator moves received bytes to a buffer anywhere in RAM.
`ifndef OTG_EVENT_REGS_SVH
`define OTG_EVENT_REGS_SVH

`define OTG_ADDR_W 8
`define OTG_DATA_W 32
`define OTG_OFS_FLAGS 8'h00
`define OTG_OFS_ENABLES 8'h04
`define OTG_OFS_CONTROL 8'h08
`define OTG_OFS_STATE 8'h0c
`define OTG_OFS_DMA_BASE 8'h10

`define OTG_BIT_ID 7
`define OTG_BIT_MS 6
`define OTG_BIT_LINE 5
`define OTG_BIT_ACT 4
`define OTG_BIT_SESVD 3
`define OTG_BIT_SESEND 2
`define OTG_BIT_SUPPLY 0
`define OTG_FLAG_MASK 8'hfd
`define OTG_FLAG_RESET 8'h00

`define OTG_CTL_SUSPEND 0
`define OTG_CTL_ROLE_LO 1
`define OTG_CTL_ROLE_HI 2
`define OTG_CTL_STALL 3

`define OTG_PIN_COUNT 5
`define OTG_PIN_ID 0
`define OTG_PIN_DP 1
`define OTG_PIN_DM 2
`define OTG_PIN_SUPPLY 3
`define OTG_PIN_SESEND 4
// Cycles after reset release until the synchronised levels and their one-cycle-old copy both show the real pins.
`define OTG_SYNC_SETTLE 3'h5

`define OTG_CLK_PERIOD_NS 8
`define OTG_MS_NS 1000000
`define OTG_MS_CYCLES (`OTG_MS_NS / `OTG_CLK_PERIOD_NS)
`define OTG_CNT_W 17
`define OTG_REF_MHZ 8'd125
`define OTG_BIT_MHZ 8'd48

`define OTG_PID_ACK 8'hd2
`define OTG_PID_STALL 8'h1e

`endif

// >>> design/otg_event_pkg.sv
/*
 Types shared by the OTG event-flag block.
 Assumes nothing beyond a SystemVerilog package scope.
*/
package otg_event_pkg;

	typedef enum logic [2:0] {
		ROLE_HOST = 3'b001,
		ROLE_DEVICE = 3'b010,
		ROLE_DUAL = 3'b100
	} role_e;

	typedef enum logic [1:0] {
		PWR_RUN = 2'b01,
		PWR_SUSPEND = 2'b10
	} power_e;

endpackage : otg_event_pkg

// >>> design/otg_pins_if.sv
/*
 Carrier for the synchronised bus and comparator levels.
 Assumes one clock domain on both ends.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

interface otg_pins_if;
	logic [`OTG_PIN_COUNT-1:0] level;

	modport src (output level);
	modport dst (input level);
endinterface : otg_pins_if

`default_nettype wire

// >>> design/pin_sync.sv
/*
 Three-stage synchroniser for the asynchronous bus and comparator pins.
 Assumes ref_clk and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

module pin_sync (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [`OTG_PIN_COUNT-1:0] raw,
	otg_pins_if.src pins
);

	logic [`OTG_PIN_COUNT-1:0] meta_reg;
	logic [`OTG_PIN_COUNT-1:0] sync2_reg;
	logic [`OTG_PIN_COUNT-1:0] sync3_reg;
	logic [`OTG_PIN_COUNT-1:0] level_reg;

	genvar i;
	generate
		for (i = 0; i < `OTG_PIN_COUNT; i++) begin : g_pin
			// A level only counts once the last two stages agree.
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					meta_reg[i] <= 1'b0;
					sync2_reg[i] <= 1'b0;
					sync3_reg[i] <= 1'b0;
					level_reg[i] <= 1'b0;
				end else begin
					meta_reg[i] <= raw[i];
					sync2_reg[i] <= meta_reg[i];
					sync3_reg[i] <= sync2_reg[i];
					if (sync2_reg[i] == sync3_reg[i]) begin
						level_reg[i] <= sync3_reg[i];
					end
				end
			end
		end
	endgenerate

	assign pins.level = level_reg;

endmodule : pin_sync

`default_nettype wire

// >>> design/steady_timer.sv
/*
 Watches a two-bit line state and pulses once it has held for a set time.
 Assumes ref_clk and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

module steady_timer #(
	parameter logic [`OTG_CNT_W-1:0] HOLD_CYCLES = `OTG_CNT_W'(`OTG_MS_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [1:0] line,
	output logic steady,
	output logic [1:0] steady_line
);

	logic [1:0] held_reg;
	logic [`OTG_CNT_W-1:0] count_reg;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			held_reg <= 2'h0;
			count_reg <= '0;
			steady <= 1'b0;
		end else begin
			held_reg <= line;
			steady <= 1'b0;
			if (line != held_reg) begin
				count_reg <= '0;
			end else if (count_reg != HOLD_CYCLES) begin
				count_reg <= count_reg + 1'b1;
				// Pulse exactly once per steady stretch, then hold the count.
				steady <= (count_reg == HOLD_CYCLES - 1'b1);
			end
		end
	end

	assign steady_line = held_reg;

endmodule : steady_timer

`default_nettype wire

// >>> design/otg_event_flags.sv
/*
 Event flags, interrupt enables and interrupt output of the USB OTG block,
 with the bit-rate enable, role select, handshake reply and receive DMA address.
 Assumes a 125 MHz ref_clk, a single-cycle register port with read data one
 cycle after the read strobe, and asynchronous bus and comparator pins.
*/
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

module otg_event_flags #(
	parameter logic [`OTG_CNT_W-1:0] MS_CYCLES = `OTG_CNT_W'(`OTG_MS_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [`OTG_ADDR_W-1:0] addr,
	input wire logic [`OTG_DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [`OTG_DATA_W-1:0] rd_data,
	input wire logic cable_id_pin,
	input wire logic dp_pin,
	input wire logic dm_pin,
	input wire logic supply_valid_cmp,
	input wire logic session_end_cmp,
	input wire logic rx_packet_ok,
	input wire logic rx_packet_bad,
	input wire logic rx_byte_strobe,
	output logic irq,
	output logic bit_clk_en,
	output otg_event_pkg::role_e role,
	output logic suspended,
	output logic handshake_valid,
	output logic [7:0] handshake_pid,
	output logic dma_write,
	output logic [`OTG_DATA_W-1:0] dma_addr
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and line state.

	otg_pins_if pins ();

	logic [`OTG_PIN_COUNT-1:0] raw_pins;
	logic [`OTG_PIN_COUNT-1:0] prev_reg;
	logic [`OTG_PIN_COUNT-1:0] pin_edge;
	logic [1:0] line;
	logic [1:0] steady_line;
	logic [1:0] reported_reg;
	logic line_steady;
	logic [2:0] settle_reg;

	assign raw_pins = {session_end_cmp, supply_valid_cmp, dm_pin, dp_pin, cable_id_pin};

	pin_sync u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.raw(raw_pins),
		.pins(pins.src)
	);

	// Line state is {single-ended zero, J state} as seen at full speed.
	assign line = {~pins.level[`OTG_PIN_DP] & ~pins.level[`OTG_PIN_DM],
		pins.level[`OTG_PIN_DP] & ~pins.level[`OTG_PIN_DM]};

	steady_timer #(
		.HOLD_CYCLES(MS_CYCLES)
	) u_steady (
		.ref_clk(ref_clk),
		.reset(reset),
		.line(line),
		.steady(line_steady),
		.steady_line(steady_line)
	);

	// The synchroniser leaves reset at zero and needs a few cycles to show
	// the real pins. Edges are ignored until then, so a pin that sits high
	// after reset does not fake a change and raise a spurious interrupt.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			prev_reg <= '0;
			settle_reg <= 3'h0;
		end else begin
			prev_reg <= pins.level;
			if (settle_reg != `OTG_SYNC_SETTLE) begin
				settle_reg <= settle_reg + 3'h1;
			end
		end
	end

	assign pin_edge = (settle_reg == `OTG_SYNC_SETTLE) ? (pins.level ^ prev_reg) : '0;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reported_reg <= 2'h0;
		end else if (line_steady && steady_line != reported_reg) begin
			reported_reg <= steady_line;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Timers: 1 ms tick and 48 MHz bit-rate enable.

	logic [`OTG_CNT_W-1:0] ms_count_reg;
	logic ms_tick;
	logic [7:0] phase_reg;
	logic [7:0] phase_sum;

	assign ms_tick = (ms_count_reg == MS_CYCLES - 1'b1);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ms_count_reg <= '0;
		end else if (ms_tick) begin
			ms_count_reg <= '0;
		end else begin
			ms_count_reg <= ms_count_reg + 1'b1;
		end
	end

	// Fractional divider: 48 pulses every 125 cycles. The enable jitters by
	// one ref_clk period, which the bit sampler must tolerate.
	// The phase stays below 125 + 48, so eight bits never overflow.
	assign phase_sum = phase_reg + `OTG_BIT_MHZ;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_reg <= 8'h00;
			bit_clk_en <= 1'b0;
		end else if (phase_sum >= `OTG_REF_MHZ) begin
			phase_reg <= phase_sum - `OTG_REF_MHZ;
			bit_clk_en <= 1'b1;
		end else begin
			phase_reg <= phase_sum;
			bit_clk_en <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register: suspend request, role and endpoint stall.

	logic ctl_wr;
	logic [1:0] role_sel;
	logic stall_reg;
	logic suspend_req;
	logic bus_activity;
	otg_event_pkg::power_e power_reg;

	assign ctl_wr = wr_en && (addr == `OTG_OFS_CONTROL);
	assign role_sel = wr_data[`OTG_CTL_ROLE_HI:`OTG_CTL_ROLE_LO];
	assign suspend_req = ctl_wr && wr_data[`OTG_CTL_SUSPEND];
	assign bus_activity = |{pin_edge[`OTG_PIN_ID], pin_edge[`OTG_PIN_DP],
		pin_edge[`OTG_PIN_DM], pin_edge[`OTG_PIN_SUPPLY]};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			role <= otg_event_pkg::ROLE_HOST;
		end else if (ctl_wr) begin
			// Code 3 keeps the current role, so a write that only touches
			// suspend or stall need not know which role is in force.
			case (role_sel)
				2'h0: role <= otg_event_pkg::ROLE_HOST;
				2'h1: role <= otg_event_pkg::ROLE_DEVICE;
				2'h2: role <= otg_event_pkg::ROLE_DUAL;
				default: role <= role;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			stall_reg <= 1'b0;
		end else if (ctl_wr) begin
			stall_reg <= wr_data[`OTG_CTL_STALL];
		end
	end

	// Activity wins over a suspend request in the same cycle, so a wake-up
	// is never swallowed by the write that would have put the block to sleep.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			power_reg <= otg_event_pkg::PWR_RUN;
		end else begin
			case (power_reg)
				otg_event_pkg::PWR_RUN: begin
					if (suspend_req && !bus_activity) begin
						power_reg <= otg_event_pkg::PWR_SUSPEND;
					end
				end
				otg_event_pkg::PWR_SUSPEND: begin
					if (bus_activity) begin
						power_reg <= otg_event_pkg::PWR_RUN;
					end
				end
				default: power_reg <= otg_event_pkg::PWR_RUN;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			suspended <= 1'b0;
		end else begin
			suspended <= (power_reg == otg_event_pkg::PWR_SUSPEND);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Event flags, enables and interrupt.

	logic [7:0] flags_reg;
	logic [7:0] enables_reg;
	logic [7:0] events;
	logic [7:0] clear_mask;
	logic woke;

	// While running, pin changes are ordinary traffic; only a wake-up counts.
	assign woke = (power_reg == otg_event_pkg::PWR_SUSPEND) && bus_activity;

	always_comb begin
		events = 8'h00;
		events[`OTG_BIT_ID] = pin_edge[`OTG_PIN_ID];
		events[`OTG_BIT_MS] = ms_tick;
		events[`OTG_BIT_LINE] = line_steady && (steady_line != reported_reg);
		events[`OTG_BIT_ACT] = woke;
		// The session end comparator rising means the supply dropped below the
		// session end level; either edge of it is a session end change.
		events[`OTG_BIT_SESVD] = pin_edge[`OTG_PIN_SESEND] && pins.level[`OTG_PIN_SESEND];
		events[`OTG_BIT_SESEND] = pin_edge[`OTG_PIN_SESEND];
		events[`OTG_BIT_SUPPLY] = pin_edge[`OTG_PIN_SUPPLY];
	end

	// Only a software write clears a flag; hardware never clears one itself.
	assign clear_mask = (wr_en && addr == `OTG_OFS_FLAGS) ? wr_data[7:0] : 8'h00;

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			flags_reg <= `OTG_FLAG_RESET;
		end else begin
			// A new event outweighs a clear in the same cycle.
			flags_reg <= ((flags_reg & ~clear_mask) | events) & `OTG_FLAG_MASK;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			enables_reg <= `OTG_FLAG_RESET;
		end else if (wr_en && addr == `OTG_OFS_ENABLES) begin
			enables_reg <= wr_data[7:0] & `OTG_FLAG_MASK;
		end
	end

	// Registered so that irq cannot glitch while flags and enables change.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_reg & enables_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Handshake reply and receive DMA address.

	logic [`OTG_DATA_W-1:0] dma_base_reg;
	logic [`OTG_DATA_W-1:0] dma_offset_reg;
	logic base_wr;

	assign base_wr = wr_en && (addr == `OTG_OFS_DMA_BASE);

	// A corrupt packet gets no reply at all, so the sender times out and retries.
	// The reply code is held between packets, so it may be read late.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			handshake_valid <= 1'b0;
			handshake_pid <= 8'h00;
		end else begin
			handshake_valid <= rx_packet_ok && !rx_packet_bad && !suspended;
			if (rx_packet_ok) begin
				handshake_pid <= stall_reg ? `OTG_PID_STALL : `OTG_PID_ACK;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dma_base_reg <= '0;
		end else if (base_wr) begin
			dma_base_reg <= wr_data;
		end
	end

	// A packet end restarts the offset even when a byte comes with it, so
	// that byte still lands at the old offset and the next packet at the base.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			dma_offset_reg <= '0;
			dma_write <= 1'b0;
			dma_addr <= '0;
		end else begin
			dma_write <= rx_byte_strobe;
			if (rx_byte_strobe) begin
				dma_addr <= dma_base_reg + dma_offset_reg;
			end
			if (base_wr || rx_packet_ok || rx_packet_bad) begin
				dma_offset_reg <= '0;
			end else if (rx_byte_strobe) begin
				dma_offset_reg <= dma_offset_reg + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register read port.

	logic [`OTG_DATA_W-1:0] rd_next;

	always_comb begin
		rd_next = '0;
		case (addr)
			`OTG_OFS_FLAGS: rd_next = {24'h000000, flags_reg};
			`OTG_OFS_ENABLES: rd_next = {24'h000000, enables_reg};
			`OTG_OFS_CONTROL: rd_next = {28'h0000000, stall_reg, 1'b0, 1'b0, suspended};
			`OTG_OFS_STATE: rd_next = {22'h000000, role, reported_reg, pins.level};
			`OTG_OFS_DMA_BASE: rd_next = dma_base_reg;
			default: rd_next = '0;
		endcase
	end

	// Read data stand for one cycle only and are zero otherwise, so a stale
	// word can never be mistaken for a fresh read.
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= rd_next;
		end else begin
			rd_data <= '0;
		end
	end

endmodule : otg_event_flags

`default_nettype wire

// >>> verif/otg_event_monitor.sv
/*
 Checker of the OTG event-flag block, bound to its top module.
 Assumes the top module's ports and the offsets of the shared register header.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

module otg_event_monitor #(
	parameter logic [`OTG_CNT_W-1:0] MS_CYCLES = `OTG_CNT_W'(`OTG_MS_CYCLES)
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [`OTG_ADDR_W-1:0] addr,
	input wire logic [`OTG_DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [`OTG_DATA_W-1:0] rd_data,
	input wire logic rx_packet_ok,
	input wire logic rx_packet_bad,
	input wire logic rx_byte_strobe,
	input wire logic irq,
	input wire logic bit_clk_en,
	input wire otg_event_pkg::role_e role,
	input wire logic suspended,
	input wire logic handshake_valid,
	input wire logic dma_write
);
	default clocking dcb @(posedge ref_clk); endclocking
	default disable iff (reset);

	////////////////////////////////////////
	// Enables are counted over 125-cycle windows; the first window is skipped because
	// it is one sample short.
	logic [6:0] win_reg;
	logic [6:0] pulses_reg;
	logic warm_reg;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			win_reg <= 7'h00;
			pulses_reg <= 7'h00;
			warm_reg <= 1'h0;
		end else if (win_reg == 7'h7c) begin
			win_reg <= 7'h00;
			pulses_reg <= 7'(bit_clk_en);
			warm_reg <= 1'h1;
		end else begin
			win_reg <= win_reg + 7'h01;
			pulses_reg <= pulses_reg + 7'(bit_clk_en);
		end
	end

	a_bit_rate: assert property (warm_reg && win_reg == 7'h7b
		|-> pulses_reg + 7'(bit_clk_en) == 7'h30) else $error("bit enable rate wrong");
	a_read_idle_zero: assert property (!$past(rd_en) |-> rd_data == 32'h0)
		else $error("read data outside read cycle");
	a_flags_unused_zero: assert property ($past(rd_en) && $past(addr) == `OTG_OFS_FLAGS
		|-> rd_data[31:8] == 24'h0 && !rd_data[1]) else $error("unused flag bits set");
	a_enable_readback: assert property (wr_en && addr == `OTG_OFS_ENABLES
		##2 rd_en && addr == `OTG_OFS_ENABLES
		|=> rd_data == ($past(wr_data, 3) & 32'h000000fd)) else $error("enable readback");
	a_irq_after_reset: assert property ($past(reset) |-> !irq) else $error("irq after reset");
	a_role_after_reset: assert property ($past(reset) |-> role == otg_event_pkg::ROLE_HOST)
		else $error("role after reset");
	a_irq_masked: assert property (wr_en && addr == `OTG_OFS_ENABLES && wr_data[7:0] == 8'h00
		|-> ##2 !irq) else $error("irq with all enables off");
	a_handshake_sent: assert property (rx_packet_ok && !rx_packet_bad && !suspended
		|=> handshake_valid) else $error("no handshake");
	a_handshake_held: assert property (!rx_packet_ok || rx_packet_bad || suspended
		|=> !handshake_valid) else $error("stray handshake");
	a_dma_per_byte: assert property (dma_write == $past(rx_byte_strobe))
		else $error("dma write not one per byte");
endmodule : otg_event_monitor

bind otg_event_flags otg_event_monitor #(.MS_CYCLES(MS_CYCLES)) u_otg_event_monitor (
	.ref_clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .rx_packet_ok,
	.rx_packet_bad, .rx_byte_strobe, .irq, .bit_clk_en, .role, .suspended,
	.handshake_valid, .dma_write
);

`default_nettype wire

// >>> verif/usb_peer_model.sv
/*
 Model of the bus lines and supply comparators facing the block.
 Assumes the bench sets the wanted levels; the pins follow them asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

module usb_peer_model (
	input wire logic [`OTG_PIN_COUNT-1:0] levels,
	output logic cable_id_pin,
	output logic dp_pin,
	output logic dm_pin,
	output logic supply_valid_cmp,
	output logic session_end_cmp
);
	////////////////////////////////////////
	// Pins move 3 ns late so that they never change on a clock edge, as real pins would not.
	assign #3 {session_end_cmp, supply_valid_cmp, dm_pin, dp_pin, cable_id_pin} = levels;
endmodule : usb_peer_model

`default_nettype wire

// >>> verif/otg_event_flags_tb.sv
/*
 Self-checking bench of the OTG event-flag block, driving its register port.
 Assumes the peer model for the pins and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "otg_event_regs.svh"

module otg_event_flags_tb;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h0;
	logic wr_en = 1'h0;
	logic rd_en = 1'h0;
	logic rx_packet_ok = 1'h0;
	logic rx_packet_bad = 1'h0;
	logic rx_byte_strobe = 1'h0;
	logic [4:0] levels = 5'h03;
	logic [31:0] rd_data;
	logic irq;
	logic suspended;
	otg_event_pkg::role_e role;
	logic handshake_valid;
	logic dma_write;
	logic [7:0] handshake_pid;
	logic [31:0] dma_addr;
	wire id_w, dp_w, dm_w, sup_w, send_w;
	logic [4:0] ev_lv [4] = '{5'h00, 5'h10, 5'h00, 5'h08};
	logic [7:0] ev_fl [4] = '{8'h80, 8'h0c, 8'h04, 8'h01};
	int err_total = 0;
	int check_count = 0;
	int cycles = 0;

	otg_event_flags #(.MS_CYCLES(`OTG_CNT_W'(20))) u_otg_event_flags (
		.ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
		.rd_en(rd_en), .rd_data(rd_data), .cable_id_pin(id_w), .dp_pin(dp_w), .dm_pin(dm_w),
		.supply_valid_cmp(sup_w), .session_end_cmp(send_w), .rx_packet_ok(rx_packet_ok),
		.rx_packet_bad(rx_packet_bad), .rx_byte_strobe(rx_byte_strobe), .irq(irq),
		.bit_clk_en(), .role(role), .suspended(suspended), .handshake_valid(handshake_valid),
		.handshake_pid(handshake_pid), .dma_write(dma_write), .dma_addr(dma_addr)
	);
	usb_peer_model u_usb_peer_model (.levels(levels), .cable_id_pin(id_w), .dp_pin(dp_w),
		.dm_pin(dm_w), .supply_valid_cmp(sup_w), .session_end_cmp(send_w));

	////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'h1;
		@(posedge ref_clk);
		wr_en <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge ref_clk);
		rd_en <= 1'h0;
		#1 chk(rd_data & m, e);
	endtask : rd
	task conclude;
		$display("checks %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : conclude

	initial begin
		forever #(`OTG_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
	end
	// The whole run takes under 1500 cycles, so 6000 means a hang.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'h0;
		rd(`OTG_OFS_FLAGS, '1, 32'h0);
		rd(`OTG_OFS_ENABLES, '1, 32'h0);
		wr(`OTG_OFS_FLAGS, '1);
		rd(`OTG_OFS_FLAGS, '1, 32'h0);
		rd(8'h40, '1, 32'h0);
		wr(`OTG_OFS_ENABLES, '1);
		rd(`OTG_OFS_ENABLES, '1, {24'h0, `OTG_FLAG_MASK});
		wr(`OTG_OFS_ENABLES, 32'h0);
		$display("test done: registers");
		repeat (40) @(posedge ref_clk);
		wr(`OTG_OFS_FLAGS, '1);
		repeat (25) @(posedge ref_clk);
		rd(`OTG_OFS_FLAGS, 32'h60, 32'h40);
		wr(`OTG_OFS_FLAGS, 32'h0);
		rd(`OTG_OFS_FLAGS, 32'h40, 32'h40);
		levels <= 5'h01;
		repeat (40) @(posedge ref_clk);
		rd(`OTG_OFS_FLAGS, 32'h20, 32'h20);
		$display("test done: timers");
		wr(`OTG_OFS_ENABLES, 32'h80);
		wr(`OTG_OFS_FLAGS, '1);
		for (int i = 0; i < 4; i++) begin
			levels <= ev_lv[i];
			repeat (10) @(posedge ref_clk);
			rd(`OTG_OFS_FLAGS, 32'h9f, {24'h0, ev_fl[i]});
			if (i == 0) chk({31'h0, irq}, 32'h1);
			wr(`OTG_OFS_FLAGS, '1);
		end
		#1 chk({31'h0, irq}, 32'h0);
		$display("test done: events");
		for (int i = 0; i < 3; i++) begin
			wr(`OTG_OFS_CONTROL, 32'(i << 1));
			repeat (2) @(posedge ref_clk);
			chk(32'(role), 32'h1 << i);
		end
		$display("test done: roles");
		wr(`OTG_OFS_DMA_BASE, 32'h00001000);
		rx_byte_strobe <= 1'h1;
		@(posedge ref_clk);
		rx_packet_ok <= 1'h1;
		#1 chk({31'h0, dma_write}, 32'h1);
		chk(dma_addr, 32'h00001000);
		@(posedge ref_clk);
		rx_packet_bad <= 1'h1;
		rx_byte_strobe <= 1'h0;
		#1 chk(dma_addr, 32'h00001001);
		chk({31'h0, handshake_valid}, 32'h1);
		chk({24'h0, handshake_pid}, {24'h0, `OTG_PID_ACK});
		@(posedge ref_clk);
		rx_packet_ok <= 1'h0;
		rx_packet_bad <= 1'h0;
		#1 chk({31'h0, handshake_valid}, 32'h0);
		wr(`OTG_OFS_CONTROL, 32'hf);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, suspended}, 32'h1);
		rx_packet_ok <= 1'h1;
		@(posedge ref_clk);
		rx_packet_ok <= 1'h0;
		#1 chk({31'h0, handshake_valid}, 32'h0);
		chk({24'h0, handshake_pid}, {24'h0, `OTG_PID_STALL});
		wr(`OTG_OFS_FLAGS, '1);
		levels <= 5'h09;
		repeat (10) @(posedge ref_clk);
		rd(`OTG_OFS_FLAGS, 32'h9f, 32'h90);
		chk({31'h0, suspended}, 32'h0);
		chk({31'h0, irq}, 32'h1);
		rd(`OTG_OFS_STATE, '1, 32'h00000249);
		rd(`OTG_OFS_CONTROL, '1, 32'h00000008);
		wr(`OTG_OFS_ENABLES, 32'h0);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		$display("test done: wake");
		conclude();
	end
endmodule : otg_event_flags_tb

`default_nettype wire
